// File: verilog/clock_gen_regs.svh
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

`define CFG_BYTES 16
`define CFG_BITS 128
`define ADDR_W 4
`define CFG_RESET 8'h00
`define REF_A_LSB 0
`define REF_B_LSB 24
`define REF_C_FIRST_LSB 48
`define REF_C_ALT_LSB 72
`define FBK_A_LSB 8
`define FBK_B_LSB 32
`define FBK_C_FIRST_LSB 56
`define FBK_C_ALT_LSB 80
`define PUMP_A_BIT 19
`define PUMP_B_BIT 43
`define PUMP_C_FIRST_BIT 67
`define PUMP_C_ALT_BIT 91
`define LOOP_A_BIT 20
`define LOOP_B_BIT 44
`define LOOP_C_FIRST_BIT 68
`define LOOP_C_ALT_BIT 92
`define SRC_A_LSB 22
`define SRC_B_LSB 46
`define SRC_C_FIRST_LSB 70
`define SRC_D_FIRST_LSB 94
`define SRC_C_ALT_LSB 124
`define SRC_D_ALT_LSB 126
`define POST_A_LSB 96
`define POST_B_LSB 100
`define POST_C_FIRST_LSB 104
`define POST_D_FIRST_LSB 108
`define POST_C_ALT_LSB 112
`define POST_D_ALT_LSB 116
`define LOOP_SHORT_US 7
`define LOOP_LONG_US 20
`define PUMP_LOW_UA 2
`define PUMP_HIGH_UA 10

`endif

// File: verilog/clock_gen_pkg.sv
package clock_gen_pkg;
  typedef logic [7:0] ref_div_t;
  typedef logic [10:0] fbk_div_t;
  typedef logic [2:0] a_count_t;
  typedef logic [7:0] m_count_t;
  typedef logic [3:0] post_code_t;
  typedef logic [5:0] post_ratio_t;
  typedef enum logic [1:0] {
    SRC_REF = 2'h0,
    SRC_PLL_A = 2'h1,
    SRC_PLL_B = 2'h2,
    SRC_PLL_C = 2'h3
  } source_e;
endpackage : clock_gen_pkg

// File: verilog/post_ratio_decode.sv
`timescale 1ns/1ns
module post_ratio_decode
  import clock_gen_pkg::*;
(
  input wire post_code_t code,
  output post_ratio_t ratio
);
  always_comb begin
    case (code)
      4'h0: ratio = 6'h01;
      4'h1: ratio = 6'h02;
      4'h2: ratio = 6'h03;
      4'h3: ratio = 6'h04;
      4'h4: ratio = 6'h05;
      4'h5: ratio = 6'h06;
      4'h6: ratio = 6'h08;
      4'h7: ratio = 6'h09;
      4'h8: ratio = 6'h0a;
      4'h9: ratio = 6'h0c;
      4'ha: ratio = 6'h0f;
      4'hb: ratio = 6'h10;
      4'hc: ratio = 6'h12;
      4'hd: ratio = 6'h14;
      4'he: ratio = 6'h19;
      default: ratio = 6'h32;
    endcase
  end
endmodule : post_ratio_decode

// File: verilog/feedback_split.sv
`timescale 1ns/1ns
module feedback_split
  import clock_gen_pkg::*;
(
  input wire fbk_div_t value,
  output a_count_t a_count,
  output m_count_t m_count
);
  assign a_count = value[2:0];
  assign m_count = value[10:3];
endmodule : feedback_split

// File: verilog/clock_gen_divider_mux_config.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "clock_gen_regs.svh"
module clock_gen_divider_mux_config
  import clock_gen_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic set_select_pin,
  output ref_div_t ref_divider_a,
  output ref_div_t ref_divider_b,
  output ref_div_t ref_divider_c,
  output a_count_t a_count_a,
  output m_count_t m_count_a,
  output a_count_t a_count_b,
  output m_count_t m_count_b,
  output a_count_t a_count_c,
  output m_count_t m_count_c,
  output logic loop_filter_long_a,
  output logic loop_filter_long_b,
  output logic loop_filter_long_c,
  output logic pump_high_a,
  output logic pump_high_b,
  output logic pump_high_c,
  output source_e source_a,
  output source_e source_b,
  output source_e source_c,
  output source_e source_d,
  output post_ratio_t post_ratio_a,
  output post_ratio_t post_ratio_b,
  output post_ratio_t post_ratio_c,
  output post_ratio_t post_ratio_d,
  output logic output_glitch_risk
);
  typedef struct packed {
    logic [`CFG_BITS-1:0] cfg;
    logic [7:0] rdata;
    logic sel;
    logic glitch;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [`CFG_BITS-1:0] wr_mask;
  logic [`CFG_BITS-1:0] out_ctl_mask;
  logic [`CFG_BITS-1:0] cfg;
  fbk_div_t fbk_c;
  post_code_t post_c;
  post_code_t post_d;

  assign cfg = st_ff.cfg;

  // Bits that reach muxes and post dividers
  always_comb begin
    out_ctl_mask = '0;
    out_ctl_mask[`SRC_A_LSB +: 2] = 2'h3;
    out_ctl_mask[`SRC_B_LSB +: 2] = 2'h3;
    out_ctl_mask[`SRC_C_FIRST_LSB +: 2] = 2'h3;
    out_ctl_mask[`SRC_D_FIRST_LSB +: 2] = 2'h3;
    out_ctl_mask[`SRC_C_ALT_LSB +: 4] = 4'hf;
    out_ctl_mask[`POST_A_LSB +: 24] = 24'hffffff;
  end

  always_comb begin
    wr_mask = '0;
    wr_mask[{addr, 3'h0} +: 8] = 8'hff;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sel = set_select_pin;
    nxt_st.glitch = 1'b0;
    if (wr) begin
      nxt_st.cfg[{addr, 3'h0} +: 8] = wdata;
      nxt_st.glitch = |(wr_mask & out_ctl_mask & ({16{wdata}} ^ st_ff.cfg));
    end
    if (set_select_pin != st_ff.sel) begin
      nxt_st.glitch = 1'b1;
    end
    if (rd) begin
      nxt_st.rdata = st_ff.cfg[{addr, 3'h0} +: 8];
    end else begin
      nxt_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign output_glitch_risk = st_ff.glitch;

  assign ref_divider_a = cfg[`REF_A_LSB +: 8];
  assign ref_divider_b = cfg[`REF_B_LSB +: 8];
  assign ref_divider_c = st_ff.sel ? cfg[`REF_C_ALT_LSB +: 8] : cfg[`REF_C_FIRST_LSB +: 8];

  assign fbk_c = st_ff.sel ? cfg[`FBK_C_ALT_LSB +: 11] : cfg[`FBK_C_FIRST_LSB +: 11];

  feedback_split split_a (
    .value(cfg[`FBK_A_LSB +: 11]),
    .a_count(a_count_a),
    .m_count(m_count_a)
  );

  feedback_split split_b (
    .value(cfg[`FBK_B_LSB +: 11]),
    .a_count(a_count_b),
    .m_count(m_count_b)
  );

  feedback_split split_c (
    .value(fbk_c),
    .a_count(a_count_c),
    .m_count(m_count_c)
  );

  assign loop_filter_long_a = cfg[`LOOP_A_BIT];
  assign loop_filter_long_b = cfg[`LOOP_B_BIT];
  assign loop_filter_long_c = st_ff.sel ? cfg[`LOOP_C_ALT_BIT] : cfg[`LOOP_C_FIRST_BIT];
  assign pump_high_a = cfg[`PUMP_A_BIT];
  assign pump_high_b = cfg[`PUMP_B_BIT];
  assign pump_high_c = st_ff.sel ? cfg[`PUMP_C_ALT_BIT] : cfg[`PUMP_C_FIRST_BIT];

  assign source_a = source_e'(cfg[`SRC_A_LSB +: 2]);
  assign source_b = source_e'(cfg[`SRC_B_LSB +: 2]);
  assign source_c = source_e'(st_ff.sel ? cfg[`SRC_C_ALT_LSB +: 2] : cfg[`SRC_C_FIRST_LSB +: 2]);
  assign source_d = source_e'(st_ff.sel ? cfg[`SRC_D_ALT_LSB +: 2] : cfg[`SRC_D_FIRST_LSB +: 2]);

  assign post_c = st_ff.sel ? cfg[`POST_C_ALT_LSB +: 4] : cfg[`POST_C_FIRST_LSB +: 4];
  assign post_d = st_ff.sel ? cfg[`POST_D_ALT_LSB +: 4] : cfg[`POST_D_FIRST_LSB +: 4];

  post_ratio_decode dec_a (
    .code(cfg[`POST_A_LSB +: 4]),
    .ratio(post_ratio_a)
  );

  post_ratio_decode dec_b (
    .code(cfg[`POST_B_LSB +: 4]),
    .ratio(post_ratio_b)
  );

  post_ratio_decode dec_c (
    .code(post_c),
    .ratio(post_ratio_c)
  );

  post_ratio_decode dec_d (
    .code(post_d),
    .ratio(post_ratio_d)
  );
endmodule : clock_gen_divider_mux_config

// File: testbench/cfg_master.sv
`timescale 1ns/1ns
module cfg_master (
  input wire logic sys_clk,
  input wire logic [7:0] rdata,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial {addr, wdata, wr, rd} = '0;
  task put(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {wdata, wr} <= {~d, 1'b0};
  endtask : put
  task get(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : get
endmodule : cfg_master

// File: testbench/cfg_checker.sv
`timescale 1ns/1ns
module cfg_checker
  import clock_gen_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic set_select_pin,
  input wire ref_div_t ref_divider_a,
  input wire a_count_t a_count_a,
  input wire logic loop_filter_long_a,
  input wire logic pump_high_a,
  input wire source_e source_a,
  input wire post_ratio_t post_ratio_a,
  input wire logic output_glitch_risk
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ref_write_a: assert property (wr && addr == 4'h0 |=> ref_divider_a == $past(wdata)) else $error("ref");
  fbk_split_a: assert property (wr && addr == 4'h1 |=> a_count_a == $past(wdata[2:0])) else $error("fbk");
  pump_bit_a: assert property (wr && addr == 4'h2 |=> pump_high_a == $past(wdata[3])) else $error("pump");
  loop_bit_a: assert property (wr && addr == 4'h2 |=> loop_filter_long_a == $past(wdata[4])) else $error("loop");
  src_sel_a: assert property (wr && addr == 4'h2 |=> source_a == $past(wdata[7:6])) else $error("src");
  post_top_a: assert property (wr && addr == 4'hc && wdata[3:0] == 4'hf |=> post_ratio_a == 6'h32) else $error("post");
  read_back_a: assert property (rd && addr == 4'h0 |=> rdata == ref_divider_a) else $error("read");
  glitch_flag_a: assert property (wr && addr == 4'h2 && wdata[7:6] != source_a |=> output_glitch_risk) else $error("glitch");
  cover property (wr && addr == 4'hc);
  cover property (rd);
  select_glitch_a: assert property ($changed(set_select_pin) |=> output_glitch_risk) else $error("select glitch");
  cover property (output_glitch_risk);
  cover property ($changed(set_select_pin));
endmodule : cfg_checker
bind clock_gen_divider_mux_config cfg_checker cfg_checker_i (.*);

// File: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import clock_gen_pkg::*;
  localparam logic [47:0] AB = 48'ha1_13_42_5e_2d_81;
  localparam logic [47:0] CD = 48'h84_39_a5_5b_c6_5a;
  localparam logic [5:0] RATIO [16] = '{6'h1, 6'h2, 6'h3, 6'h4, 6'h5, 6'h6, 6'h8, 6'h9,
    6'ha, 6'hc, 6'hf, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};
  logic sys_clk = 1'b0, reset_n = 1'b0, set_select_pin = 1'b0, wr, rd, output_glitch_risk;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  ref_div_t ref_divider_a, ref_divider_b, ref_divider_c;
  a_count_t a_count_a, a_count_b, a_count_c;
  m_count_t m_count_a, m_count_b, m_count_c;
  logic loop_filter_long_a, loop_filter_long_b, loop_filter_long_c, pump_high_a, pump_high_b, pump_high_c;
  source_e source_a, source_b, source_c, source_d;
  post_ratio_t post_ratio_a, post_ratio_b, post_ratio_c, post_ratio_d;
  int num_errors = 0, n_tests = 0;
  always #20 sys_clk = ~sys_clk;
  clock_gen_divider_mux_config clock_gen_divider_mux_config_i (.*);
  cfg_master cfg_master_i (.*);
  task chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask : chk
  task tally_and_finish;
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task reset_state;
    for (int i = 0; i < 16; i++) begin
      cfg_master_i.get(4'(i), d);
      chk(d, 0);
    end
    chk({post_ratio_a, source_d}, {6'h1, 2'h0});
  endtask : reset_state
  task pll_a_b;
    for (int i = 0; i < 6; i++) cfg_master_i.put(4'(i), AB[8*i+:8]);
    @(negedge sys_clk);
    chk({ref_divider_a, a_count_a, m_count_a, loop_filter_long_a, pump_high_a, source_a},
      {8'h81, 3'h5, 8'hc5, 2'h3, 2'h1});
    chk({ref_divider_b, a_count_b, m_count_b, loop_filter_long_b, pump_high_b, source_b},
      {8'h42, 3'h3, 8'h22, 2'h0, 2'h2});
    cfg_master_i.get(4'h5, d);
    chk(d, 8'ha1);
  endtask : pll_a_b
  task pll_c_select;
    for (int i = 6; i < 12; i++) cfg_master_i.put(4'(i), CD[8*i-48+:8]);
    cfg_master_i.put(4'hd, 8'h3c);
    cfg_master_i.put(4'he, 8'h96);
    cfg_master_i.put(4'hf, 8'h70);
    @(negedge sys_clk);
    chk({ref_divider_c, a_count_c, m_count_c, loop_filter_long_c, pump_high_c, source_c, source_d},
      {8'h5a, 3'h6, 8'h78, 2'h3, 2'h1, 2'h2});
    chk({post_ratio_d, post_ratio_c}, {RATIO[3], RATIO[12]});
    @(posedge sys_clk);
    set_select_pin <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(output_glitch_risk, 1'b1);
    chk({ref_divider_c, a_count_c, m_count_c, loop_filter_long_c, pump_high_c, source_c, source_d},
      {8'ha5, 3'h1, 8'h87, 2'h0, 2'h3, 2'h1});
    chk({post_ratio_d, post_ratio_c}, {RATIO[9], RATIO[6]});
    @(negedge sys_clk);
    chk(output_glitch_risk, 1'b0);
  endtask : pll_c_select
  task post_and_mux;
    for (int c = 0; c < 16; c++) begin
      cfg_master_i.put(4'hc, {4'(c), 4'(c)});
      @(negedge sys_clk);
      chk({post_ratio_b, post_ratio_a, output_glitch_risk}, {RATIO[c], RATIO[c], c != 0});
      cfg_master_i.put(4'h2, {2'(c), 6'h0});
      @(negedge sys_clk);
      chk({source_a, output_glitch_risk}, {2'(c), 1'b1});
      cfg_master_i.put(4'he, {4'(15 - c), 4'(c)});
      @(negedge sys_clk);
      chk({post_ratio_d, post_ratio_c, output_glitch_risk}, {RATIO[15-c], RATIO[c], 1'b1});
    end
    @(posedge sys_clk);
    set_select_pin <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({post_ratio_d, post_ratio_c, source_c, output_glitch_risk}, {RATIO[3], RATIO[12], 2'h1, 1'b1});
  endtask : post_and_mux
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    reset_state;
    pll_a_b;
    pll_c_select;
    post_and_mux;
    tally_and_finish;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
endmodule : testbench
